// File: rtl/translation_descriptor_decoder.sv
// Purpose: decode fetched translation descriptors and update history bits
// Assumes: walk sequencer presents each descriptor address with desc_start
// Notes: one descriptor per request; results accumulate until the page level
`timescale 1ns/1ps
module translation_descriptor_decoder
  import desc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // configuration
  input wire logic translation_control_register,
  // request from the walk sequencer
  input wire logic desc_start,
  input wire desc_pkg::level_t desc_level,
  input wire logic [31:0] desc_addr,
  input wire logic [31:0] logical_addr,
  input wire logic access_write,
  input wire logic access_rmw,
  input wire logic access_super,
  input wire logic ext_transfer,
  // memory
  output logic mem_rd,
  output logic mem_wr,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // results
  output logic desc_done,
  output logic [31:0] next_addr_reg,
  output logic walk_end_reg,
  output logic resident_reg,
  output logic error_reg,
  output logic wprot_reg,
  output logic super_viol_reg,
  output logic [19:0] frame_reg,
  output logic [31:0] phys_addr_reg,
  output logic [1:0] cache_policy_reg,
  output logic global_reg,
  output logic flush_keep,
  input wire logic flush_nonglobal,
  output logic page_attr_out_zero,
  output logic page_attr_out_one
);
  import desc_pkg::*;

  state_t state_reg;
  level_t level_reg;
  logic [31:0] word;
  logic fetch_start, fetch_busy, fetch_done, page_8k;
  logic [31:0] wr_word_reg;
  logic [19:0] pf_frame;
  logic [1:0] pf_cache;
  logic pf_a0, pf_a1, pf_glob, pf_super;
  logic [1:0] dtype;
  logic wr_cyc;
  logic attr0_reg, attr1_reg;
  logic [31:0] mark_word;
  logic is_write, prot_viol;

  // upper-level type: high bit alone tells resident
  function automatic logic upper_resident(input logic [1:0] t);
    return t[1];
  endfunction

  // page-level type: nonzero and not indirect means resident
  function automatic logic page_resident(input logic [1:0] t);
    return (t != PAGE_INVALID) && (t != PAGE_INDIRECT);
  endfunction

  assign page_8k = translation_control_register;
  assign dtype = word[TYPE_MSB:TYPE_LSB];
  assign fetch_start = (state_reg == ST_FETCH);

  fetch_port u_fetch (
    .clock(clock),
    .arst_n(arst_n),
    .start(fetch_start),
    .addr(desc_addr),
    .busy(fetch_busy),
    .done(fetch_done),
    .word_reg(word),
    .mem_rd(),
    .mem_addr(),
    .mem_ack(mem_ack && !wr_cyc),
    .mem_rdata(mem_rdata)
  );

  page_fields u_fields (
    .word(word),
    .page_8k(page_8k),
    .frame(pf_frame),
    .cache_policy_field(pf_cache),
    .page_attribute_zero(pf_a0),
    .page_attribute_one(pf_a1),
    .global_flag(pf_glob),
    .super_only(pf_super)
  );

  // memory port: reads by the fetch unit, history writes by this module
  assign wr_cyc = (state_reg == ST_WRITE);
  assign mem_rd = fetch_busy;
  assign mem_wr = wr_cyc;
  assign mem_addr = {desc_addr[31:2], 2'h0};
  assign mem_wdata = wr_word_reg;
  assign desc_done = (state_reg == ST_DONE);

  // sequencer: fetch, decode, optional history write-back
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (desc_start) begin
            state_reg <= ST_FETCH;
          end
        end
        ST_FETCH: state_reg <= ST_DECODE;
        ST_DECODE: begin
          if (fetch_done) begin
            state_reg <= ST_MARK;
          end
        end
        ST_MARK: begin
          // write back only when a history bit actually changes
          if (mark_word != word) begin
            state_reg <= ST_WRITE;
          end else begin
            state_reg <= ST_DONE;
          end
        end
        ST_WRITE: begin
          if (mem_ack) begin
            state_reg <= ST_DONE;
          end
        end
        ST_DONE: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // level latched with the request
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      level_reg <= LVL_ROOT;
    end else if (state_reg == ST_IDLE && desc_start) begin
      level_reg <= desc_level;
    end
  end

  // write-back word: marked copy of the captured descriptor, held through the write
  // (memory read data is only valid with the ack, so never sample it here)
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_word_reg <= 32'h0;
    end else if (state_reg == ST_MARK) begin
      wr_word_reg <= mark_word;
    end
  end

  // result decode per level
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      next_addr_reg <= 32'h0;
      walk_end_reg <= 1'b0;
      resident_reg <= 1'b0;
      error_reg <= 1'b0;
      wprot_reg <= 1'b0;
      super_viol_reg <= 1'b0;
      frame_reg <= 20'h0;
      phys_addr_reg <= 32'h0;
      cache_policy_reg <= CACHE_WT;
      global_reg <= 1'b0;
      attr0_reg <= 1'b0;
      attr1_reg <= 1'b0;
    end else if (state_reg == ST_FETCH && level_reg == LVL_ROOT) begin
      wprot_reg <= 1'b0;
      error_reg <= 1'b0;
      walk_end_reg <= 1'b0;
      resident_reg <= 1'b0;
    end else if (state_reg == ST_MARK) begin
      case (level_reg)
        LVL_ROOT, LVL_PTR: begin
          if (!upper_resident(dtype)) begin
            walk_end_reg <= 1'b1;
            resident_reg <= 1'b0;
          end else begin
            wprot_reg <= wprot_reg | word[WPROT_BIT];
            if (level_reg == LVL_ROOT) begin
              next_addr_reg <= {word[31:ROOT_BASE_LSB], 9'h0};
            end else if (page_8k) begin
              next_addr_reg <= {word[31:PTR8_BASE_LSB], 7'h0};
            end else begin
              next_addr_reg <= {word[31:PTR4_BASE_LSB], 8'h0};
            end
          end
        end
        default: begin
          walk_end_reg <= 1'b1;
          if (dtype == PAGE_INVALID) begin
            resident_reg <= 1'b0;
          end else if (dtype == PAGE_INDIRECT) begin
            if (level_reg == LVL_IND) begin
              error_reg <= 1'b1;
              resident_reg <= 1'b0;
            end else begin
              walk_end_reg <= 1'b0;
              next_addr_reg <= {word[31:IND_LSB], 2'h0};
            end
          end else begin
            resident_reg <= 1'b1;
            frame_reg <= pf_frame;
            phys_addr_reg <= page_8k ? {pf_frame[19:1], logical_addr[12:0]}
                                     : {pf_frame, logical_addr[11:0]};
            // cache policy passed to the entry
            cache_policy_reg <= pf_cache;
            global_reg <= pf_glob;
            wprot_reg <= wprot_reg | word[WPROT_BIT];
            super_viol_reg <= pf_super && !access_super;
            attr0_reg <= pf_a0;
            attr1_reg <= pf_a1;
          end
        end
      endcase
    end
  end

  // history update value built in the mark step
  assign is_write = access_write || access_rmw;
  assign prot_viol = wprot_reg || word[WPROT_BIT] || (pf_super && !access_super);
  always_comb begin
    mark_word = word;
    if ((level_reg == LVL_ROOT || level_reg == LVL_PTR) && upper_resident(dtype)) begin
      mark_word[USED_BIT] = 1'b1;
    end else if ((level_reg == LVL_PAGE || level_reg == LVL_IND) && page_resident(dtype)) begin
      mark_word[USED_BIT] = 1'b1;
      if (is_write && !prot_viol) begin
        mark_word[MOD_BIT] = 1'b1;
      end
    end
  end

  // global entry kept by nonglobal flush
  assign flush_keep = flush_nonglobal && global_reg;
  assign page_attr_out_zero = ext_transfer & attr0_reg;
  assign page_attr_out_one = ext_transfer & attr1_reg;

  // assertions
  a_write_sets_used: assert property (@(posedge clock) disable iff (!arst_n)
    wr_cyc && mem_ack |-> mem_wdata[USED_BIT]) else $error("used bit not set");
  a_nocyc_on_same: assert property (@(posedge clock) disable iff (!arst_n)
    state_reg == ST_MARK && mark_word == word |=> state_reg == ST_DONE)
    else $error("needless write");
  a_indirect_error: assert property (@(posedge clock) disable iff (!arst_n)
    state_reg == ST_MARK && level_reg == LVL_IND && dtype == PAGE_INDIRECT
    |=> error_reg && !resident_reg) else $error("second hop not error");
  a_invalid_page: assert property (@(posedge clock) disable iff (!arst_n)
    state_reg == ST_MARK && level_reg == LVL_PAGE && dtype == PAGE_INVALID
    |=> !resident_reg && walk_end_reg) else $error("invalid page resident");
  a_upper_absent: assert property (@(posedge clock) disable iff (!arst_n)
    state_reg == ST_MARK && (level_reg == LVL_ROOT || level_reg == LVL_PTR) && !dtype[1]
    |=> walk_end_reg && !resident_reg) else $error("absent table resident");
  a_wprot_sticky: assert property (@(posedge clock) disable iff (!arst_n)
    state_reg == ST_MARK && level_reg != LVL_ROOT && $past(wprot_reg) && wprot_reg
    |=> wprot_reg) else $error("protect lost");
  a_mod_no_viol: assert property (@(posedge clock) disable iff (!arst_n)
    wr_cyc && prot_viol |-> mem_wdata[MOD_BIT] == word[MOD_BIT])
    else $error("modified set on violation");
  a_attr_echo: assert property (@(posedge clock) disable iff (!arst_n)
    !ext_transfer |-> !page_attr_out_zero && !page_attr_out_one)
    else $error("attribute without transfer");
  c_indirect: cover property (@(posedge clock) state_reg == ST_MARK && dtype == PAGE_INDIRECT);
  c_write_back: cover property (@(posedge clock) wr_cyc && mem_ack);
  c_resident: cover property (@(posedge clock) desc_done && resident_reg);
endmodule // translation_descriptor_decoder

// File: inc/desc_pkg.sv
// Purpose: shared constants and types for the translation descriptor decoder
// Assumes: 32-bit descriptors, one aligned read each
// Notes: field positions and encodings of root, pointer, page and indirect forms
package desc_pkg;
  localparam int unsigned DW = 32;
  // table descriptor fields
  localparam int unsigned ROOT_BASE_LSB = 9;
  localparam int unsigned PTR4_BASE_LSB = 8;
  localparam int unsigned PTR8_BASE_LSB = 7;
  localparam int unsigned USED_BIT = 3;
  localparam int unsigned WPROT_BIT = 2;
  localparam int unsigned TYPE_MSB = 1;
  localparam int unsigned TYPE_LSB = 0;
  // page descriptor fields
  localparam int unsigned FRAME4_LSB = 12;
  localparam int unsigned FRAME8_LSB = 13;
  localparam int unsigned GLOBAL_BIT = 10;
  localparam int unsigned ATTR1_BIT = 9;
  localparam int unsigned ATTR0_BIT = 8;
  localparam int unsigned SUPER_BIT = 7;
  localparam int unsigned CACHE_MSB = 6;
  localparam int unsigned CACHE_LSB = 5;
  localparam int unsigned MOD_BIT = 4;
  localparam int unsigned IND_LSB = 2;
  localparam int unsigned FRAME_W = 20;
  // type, cache policy, level and state encodings
  localparam logic [1:0] PAGE_INVALID = 2'h0;
  localparam logic [1:0] PAGE_INDIRECT = 2'h2;
  localparam logic [1:0] CACHE_WT = 2'h0;
  localparam logic [1:0] CACHE_CB = 2'h1;
  localparam logic [1:0] CACHE_SER = 2'h2;
  localparam logic [1:0] CACHE_NC = 2'h3;
  typedef enum logic [1:0] {
    LVL_ROOT = 2'h0,
    LVL_PTR = 2'h1,
    LVL_PAGE = 2'h2,
    LVL_IND = 2'h3
  } level_t;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_FETCH = 6'h02,
    ST_DECODE = 6'h04,
    ST_MARK = 6'h08,
    ST_WRITE = 6'h10,
    ST_DONE = 6'h20
  } state_t;
endpackage

// File: rtl/fetch_port.sv
// Purpose: single aligned word read of one descriptor, data held in a register
// Assumes: memory answers with mem_ack, data valid in that cycle
// Notes: address low two bits forced to zero
`timescale 1ns/1ps
module fetch_port
  import desc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // request side
  input wire logic start,
  input wire logic [31:0] addr,
  output logic busy,
  output logic done,
  output logic [31:0] word_reg,
  // memory side
  output logic mem_rd,
  output logic [31:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  // read strobe held until the memory answers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
      mem_addr <= 32'h0;
    end else if (start && !busy) begin
      busy <= 1'b1;
      mem_addr <= {addr[31:2], 2'h0};
    end else if (busy && mem_ack) begin
      busy <= 1'b0;
    end
  end
  // captured descriptor word and done pulse
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      word_reg <= 32'h0;
      done <= 1'b0;
    end else begin
      done <= busy && mem_ack;
      if (busy && mem_ack) begin
        word_reg <= mem_rdata;
      end
    end
  end
  assign mem_rd = busy;
endmodule // fetch_port

// File: rtl/page_fields.sv
// Purpose: split a page descriptor into frame, cache policy and attributes
// Assumes: word is a page descriptor already known resident
// Notes: combinational decode, no storage
`timescale 1ns/1ps
module page_fields
  import desc_pkg::*;
(
  // inputs
  input wire logic [31:0] word,
  input wire logic page_8k,
  // decoded fields
  output logic [19:0] frame,
  output logic [1:0] cache_policy_field,
  output logic page_attribute_zero,
  output logic page_attribute_one,
  output logic global_flag,
  output logic super_only
);
  // frame base, low bit dropped for 8k pages; reserved bits never looked at
  always_comb begin
    frame = word[31:FRAME4_LSB];
    if (page_8k) begin
      frame = {word[31:FRAME8_LSB], 1'b0};
    end
  end
  assign cache_policy_field = word[CACHE_MSB:CACHE_LSB];
  assign page_attribute_zero = word[ATTR0_BIT];
  assign page_attribute_one = word[ATTR1_BIT];
  assign global_flag = word[GLOBAL_BIT];
  assign super_only = word[SUPER_BIT];
endmodule // page_fields

// File: tb/table_memory.sv
// Purpose: system memory holding translation tables for the descriptor decoder
// Assumes: word array is loaded by the bench; answers one access at a time
// Notes: slow adds wait cycles; data toggles every cycle while not answering
`timescale 1ns/1ps
module table_memory (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // access from the decoder
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic slow,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] words [0:63];
  logic [31:0] last_addr;
  logic [2:0] wait_reg;
  // one answer per access, read data valid only with the ack
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mem_ack <= 1'b0;
      wait_reg <= 3'h0;
      mem_rdata <= 32'h5a5a_a5a5;
      last_addr <= 32'h0;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata; // released lines never hold the last word
    end else if ((mem_rd || mem_wr) && wait_reg >= (slow ? 3'h3 : 3'h0)) begin
      mem_ack <= 1'b1;
      wait_reg <= 3'h0;
      last_addr <= mem_addr;
      mem_rdata <= words[mem_addr[7:2]];
      if (mem_wr) begin
        words[mem_addr[7:2]] <= mem_wdata;
      end
    end else begin
      if (mem_rd || mem_wr) begin
        wait_reg <= wait_reg + 3'h1;
      end
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // table_memory

// File: tb/tb.sv
// Purpose: self-checking bench for the translation descriptor decoder
// Assumes: table_memory answers at the memory side, fast and slow in turn
// Notes: descriptors sit at word indexes; each walk step is one request
`timescale 1ns/1ps
module tb;
  import desc_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic page_8k = 1'b0;
  logic desc_start = 1'b0;
  level_t desc_level = LVL_ROOT;
  logic [31:0] desc_addr = 32'h0;
  logic [31:0] logical_addr = 32'h0;
  logic access_write = 1'b0, access_rmw = 1'b0, access_super = 1'b0;
  logic ext_transfer = 1'b0, flush_nonglobal = 1'b0, slow = 1'b0;
  logic mem_rd, mem_wr, mem_ack, desc_done, walk_end_reg, resident_reg, error_reg;
  logic wprot_reg, super_viol_reg, global_reg, flush_keep;
  logic page_attr_out_zero, page_attr_out_one;
  logic [31:0] mem_addr, mem_wdata, mem_rdata, next_addr_reg, phys_addr_reg;
  logic [19:0] frame_reg;
  logic [1:0] cache_policy_reg;
  int mismatches = 0;
  int num_checks = 0;
  // 40 MHz clock
  always #12.5 clock = ~clock;
  // design and memory
  translation_descriptor_decoder uut (.clock, .arst_n,
    .translation_control_register(page_8k), .desc_start, .desc_level, .desc_addr,
    .logical_addr, .access_write, .access_rmw, .access_super, .ext_transfer,
    .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .desc_done,
    .next_addr_reg, .walk_end_reg, .resident_reg, .error_reg, .wprot_reg,
    .super_viol_reg, .frame_reg, .phys_addr_reg, .cache_policy_reg, .global_reg,
    .flush_keep, .flush_nonglobal, .page_attr_out_zero, .page_attr_out_one);
  table_memory mem (.clock, .arst_n, .mem_rd, .mem_wr, .mem_addr, .mem_wdata,
    .slow, .mem_ack, .mem_rdata);
  // verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // compare a word result
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // compare a flag result
  task automatic chk_bit(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask
  // access kind for the following requests
  task automatic setup(input logic p8, w, r, s, e, input logic [31:0] la);
    @(posedge clock);
    page_8k <= p8;
    access_write <= w;
    access_rmw <= r;
    access_super <= s;
    ext_transfer <= e;
    logical_addr <= la;
  endtask
  // one descriptor request with an unaligned address, bounded wait for done
  task automatic walk(input level_t lvl, input int idx);
    @(posedge clock);
    desc_start <= 1'b1;
    desc_level <= lvl;
    desc_addr <= {idx[29:0], 2'h3};
    @(posedge clock);
    desc_start <= 1'b0;
    for (int i = 0; i < 80; i++) begin
      @(negedge clock);
      if (desc_done === 1'b1) break;
    end
    if (desc_done !== 1'b1) begin
      mismatches++;
      finish_test();
    end
    chk_bit("aligned", 1'b0, |mem.last_addr[1:0]);
    slow <= ~slow;
  endtask
  // main sequence
  initial begin
    mem.words[1] = 32'h0001_25f2;
    mem.words[2] = 32'h0000_30f6;
    mem.words[3] = 32'h0004_5e61;
    mem.words[4] = 32'h0000_50f2;
    mem.words[5] = 32'h0006_7123;
    mem.words[6] = 32'h0000_8083;
    mem.words[7] = 32'h0000_9002;
    mem.words[8] = 32'hffff_fffc;
    mem.words[9] = 32'h0000_0042;
    mem.words[10] = 32'h0000_0201;
    mem.words[16] = 32'h0000_0022;
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    flush_nonglobal <= 1'b1;
    // 4k walk through a write-protected pointer, user write
    setup(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 32'h1234_5abc);
    walk(LVL_ROOT, 1);
    chk_word("root base", 32'h0001_2400, next_addr_reg);
    chk_word("root used", 32'h0001_25fa, mem.words[1]);
    walk(LVL_PTR, 2);
    chk_word("ptr4 base", 32'h0000_3000, next_addr_reg);
    chk_bit("ptr wprot", 1'b1, wprot_reg);
    walk(LVL_PAGE, 3);
    chk_word("phys4", 32'h0004_5abc, phys_addr_reg);
    chk_word("frame4", 32'h0000_0045, {12'h0, frame_reg});
    chk_bit("global keep", 1'b1, flush_keep);
    chk_bit("attr one", 1'b1, page_attr_out_one);
    chk_bit("attr zero", 1'b0, page_attr_out_zero);
    chk_bit("resident", 1'b1, resident_reg);
    chk_word("page4 word", 32'h0004_5e69, mem.words[3]);
    // 8k walk, read-modify-write access
    setup(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 32'h0000_1fff);
    walk(LVL_ROOT, 1);
    chk_word("root kept", 32'h0001_25fa, mem.words[1]);
    walk(LVL_PTR, 4);
    chk_word("ptr8 base", 32'h0000_5080, next_addr_reg);
    walk(LVL_PAGE, 5);
    chk_word("phys8", 32'h0006_7fff, phys_addr_reg);
    chk_word("page8 word", 32'h0006_713b, mem.words[5]);
    chk_bit("nonglobal", 1'b0, flush_keep);
    chk_bit("attr zero", 1'b1, page_attr_out_zero);
    setup(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0);
    @(negedge clock);
    chk_bit("attr gated", 1'b0, page_attr_out_zero);
    // user write to a supervisor-only page
    setup(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 32'h0);
    walk(LVL_ROOT, 1);
    walk(LVL_PTR, 7);
    chk_word("ptr4 base", 32'h0000_9000, next_addr_reg);
    walk(LVL_PAGE, 6);
    chk_bit("super viol", 1'b1, super_viol_reg);
    chk_bit("wprot clear", 1'b0, wprot_reg);
    chk_word("super word", 32'h0000_808b, mem.words[6]);
    // invalid page, then indirect to indirect
    walk(LVL_PAGE, 8);
    chk_bit("invalid", 1'b0, resident_reg);
    chk_word("invalid word", 32'hffff_fffc, mem.words[8]);
    walk(LVL_PAGE, 6);
    walk(LVL_PAGE, 9);
    chk_word("indirect", 32'h0000_0040, next_addr_reg);
    walk(LVL_IND, 16);
    chk_bit("second hop", 1'b1, error_reg);
    chk_bit("second res", 1'b0, resident_reg);
    // absent next-level table
    walk(LVL_ROOT, 10);
    chk_bit("absent", 1'b0, resident_reg);
    chk_bit("absent end", 1'b1, walk_end_reg);
    chk_word("absent word", 32'h0000_0201, mem.words[10]);
    // every cache policy code, read access
    setup(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0);
    for (int c = 0; c < 4; c++) begin
      mem.words[11 + c] = 32'h000a_0009 | (32'(c) << 5);
      walk(LVL_PAGE, 11 + c);
      chk_word("cache mode", 32'(c), {30'h0, cache_policy_reg});
    end
    finish_test();
  end
endmodule // tb
